// >>> sim/fai_top_sva.sv
// Purpose: port-level timing checks for the interval block
// Assumes: one clock domain, resetn active low
// Notes:   tick counts here never lag the design's until they saturate at 31, so gaps are lower bounds
`timescale 1ns/1ps

module fai_top_chk
    import fai_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              monitor_tick,
    input wire logic [NUM_CH-1:0] adjust_down_req,
    input wire logic [NUM_CH-1:0] adjust_up_req,
    input wire logic [NUM_CH-1:0] adjust_down_grant,
    input wire logic [NUM_CH-1:0] adjust_up_grant
);
    // ****************************************************************
    // bus and adjustment checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [NUM_CH-1:0] gnt;
    logic [4:0]        gap_cnt [NUM_CH];

    // any grant is an adjustment of that channel
    assign gnt = adjust_down_grant | adjust_up_grant;

    // ticks since last grant; saturating so it never wraps to a false low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                gap_cnt[i] <= 5'h00;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (gnt[i]) begin
                    gap_cnt[i] <= 5'h00;
                end else if (monitor_tick && gap_cnt[i] != 5'h1f) begin
                    gap_cnt[i] <= gap_cnt[i] + 5'h01;
                end
            end
        end
    end

    property p_ack_lat;
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_dn_req;
        (adjust_down_grant & ~adjust_down_req) == '0;
    endproperty
    a_dn_req: assert property (p_dn_req)
        else $error("down grant without request");
    property p_up_req;
        (adjust_up_grant & ~adjust_up_req) == '0;
    endproperty
    a_up_req: assert property (p_up_req)
        else $error("up grant without request");
    property p_excl;
        (adjust_down_grant & adjust_up_grant) == '0;
    endproperty
    a_excl: assert property (p_excl)
        else $error("both directions granted");
    property p_restart;
        (gnt != '0) |=> ((gnt & $past(gnt)) == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("grant held past restart");

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        property p_dn_gap;
            adjust_down_grant[i] |-> gap_cnt[i] >= 5'h08;
        endproperty
        a_dn_gap: assert property (p_dn_gap)
            else $error("down grant too soon");
        property p_up_gap;
            adjust_up_grant[i] |-> gap_cnt[i] >= 5'h10;
        endproperty
        a_up_gap: assert property (p_up_gap)
            else $error("up grant too soon");
    end
endmodule : fai_top_chk

bind fai_top fai_top_chk u_chk (.clk(clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .monitor_tick(monitor_tick), .adjust_down_req(adjust_down_req),
    .adjust_up_req(adjust_up_req), .adjust_down_grant(adjust_down_grant),
    .adjust_up_grant(adjust_up_grant));

// >>> sim/floor_adjust_interval_config_tb.sv
// Purpose: self-checking bench for register codes and adjustment spacing
// Assumes: one tick every two clocks, requests between ticks
// Notes:   each gap row first forces a grant so the count starts at zero
`timescale 1ns/1ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %0h expected %0h", $time, g, e); end end

module floor_adjust_interval_config_tb import fai_pkg::*;;
    // ****************************************************************
    // stimulus and checking
    // ****************************************************************
    typedef struct {logic we; logic [7:0] idx, wd, ex;} fai_reg_row_s;
    typedef struct {logic [7:0] c1, cd; logic [2:0] ch; logic up;
                    int lim;} fai_gap_row_s;
    logic        clk = 1'b0, resetn = 1'b0, tick = 1'b0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [9:0]  wb_adr = '0;
    logic [3:0]  wb_sel = '0;
    logic [31:0] wb_wdat = '0, wb_rdat, rd;
    logic [2:0]  dreq = '0, ureq = '0, dgnt, ugnt, dm, um;
    int          error_cnt = 0, cmp_count = 0;
    fai_reg_row_s reg_rows [8] = '{'{1'b0, IDX_STATUS, 8'h00, 8'h3f},
        '{1'b0, IDX_CNT_R2, 8'h00, 8'h10}, '{1'b0, IDX_CODES, 8'h00, 8'h00},
        '{1'b0, IDX_CTRL1, 8'h00, 8'h00}, '{1'b0, IDX_CONFIG, 8'h00, 8'h05},
        '{1'b1, IDX_CODES, 8'ha5, 8'ha5}, '{1'b1, IDX_CTRL1, 8'hff, 8'he1},
        '{1'b1, 8'h10, 8'hff, 8'h00}};
    fai_gap_row_s gap_rows [9] = '{'{8'he1, 8'h0b, 3'h1, 1'b0, 16},
        '{8'he1, 8'h0b, 3'h1, 1'b1, 32}, '{8'he1, 8'h0b, 3'h2, 1'b0, 64},
        '{8'he1, 8'h0b, 3'h2, 1'b1, 128}, '{8'he1, 8'h0b, 3'h4, 1'b0, 128},
        '{8'he1, 8'h0b, 3'h4, 1'b1, 256}, '{8'he0, 8'h0b, 3'h4, 1'b0, 8},
        '{8'he0, 8'hcb, 3'h4, 1'b0, 64}, '{8'he1, 8'h3b, 3'h1, 1'b0, 1024}};

    fai_top u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .monitor_tick(tick), .adjust_down_req(dreq),
        .adjust_up_req(ureq), .adjust_down_grant(dgnt),
        .adjust_up_grant(ugnt));

    // free-running 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // one classic cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] idx,
                           input logic [7:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hf;
        wb_wdat <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("Error %0t: no ack", $time);
        end
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer

    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask : tick_n

    // grants are combinational, so look mid-cycle then release the request
    task automatic try_req(input logic [2:0] d, u, ed, eu);
        @(posedge clk);
        dreq <= d;
        ureq <= u;
        @(negedge clk);
        `CHK(dgnt, ed)
        `CHK(ugnt, eu)
        @(posedge clk);
        dreq <= '0;
        ureq <= '0;
    endtask : try_req

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // cut a hang short; the run needs about 10k cycles
    initial begin
        #1_000_000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        tick_n(16);
        try_req(3'h7, 3'h0, 3'h0, 3'h0);
        $display("disabled channels done");
        foreach (reg_rows[i]) begin
            if (reg_rows[i].we) wb_xfer(1'b1, reg_rows[i].idx,
                                        reg_rows[i].wd, rd);
            wb_xfer(1'b0, reg_rows[i].idx, 8'h00, rd);
            `CHK(rd[7:0], reg_rows[i].ex)
        end
        $display("register rows done");
        tick_n(1024);
        try_req(3'h7, 3'h7, 3'h7, 3'h0);
        $display("tie done");
        foreach (gap_rows[i]) begin
            wb_xfer(1'b1, IDX_CTRL1, gap_rows[i].c1, rd);
            wb_xfer(1'b1, IDX_CODES, gap_rows[i].cd, rd);
            dm = gap_rows[i].up ? 3'h0 : gap_rows[i].ch;
            um = gap_rows[i].up ? gap_rows[i].ch : 3'h0;
            tick_n(gap_rows[i].lim);
            try_req(dm, um, dm, um);
            tick_n(gap_rows[i].lim - 1);
            try_req(dm, um, 3'h0, 3'h0);
            tick_n(1);
            try_req(dm, um, dm, um);
        end
        $display("interval rows done");
        wb_xfer(1'b1, IDX_CONFIG, 8'h03, rd);
        wb_xfer(1'b1, IDX_CODES, 8'h00, rd);
        wb_xfer(1'b1, IDX_CTRL1, 8'h00, rd);
        wb_xfer(1'b0, IDX_CODES, 8'h00, rd);
        `CHK(rd[7:0], 8'h3b)
        wb_xfer(1'b0, IDX_CTRL1, 8'h00, rd);
        `CHK(rd[7:0], 8'he1)
        $display("lock done");
        // mid-run reset: read data clears at once, lock only by reset
        resetn <= 1'b0;
        @(posedge clk);
        `CHK(wb_rdat, 32'h0000_0000)
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        wb_xfer(1'b0, IDX_CTRL1, 8'h00, rd);
        `CHK(rd[7:0], 8'h00)
        wb_xfer(1'b0, IDX_CONFIG, 8'h00, rd);
        `CHK(rd[7:0], 8'h05)
        wb_xfer(1'b1, IDX_CODES, 8'h52, rd);
        wb_xfer(1'b0, IDX_CODES, 8'h00, rd);
        `CHK(rd[7:0], 8'h52)
        $display("reset done");
        report_and_stop();
    end
endmodule : floor_adjust_interval_config_tb

// >>> src/fai_interval.sv
// Purpose: one channel's spacing counter for fan-start temperature steps
// Assumes: monitor_tick is a one-cycle pulse per monitoring cycle
// Notes:   decrease wins when both directions are asked in one cycle
`timescale 1ns/1ps

module fai_interval
    import fai_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              monitor_tick,
    input  wire logic              enable,
    input  wire logic [2:0]        interval_code,
    input  wire logic              down_req,
    input  wire logic              up_req,
    output logic                   down_grant,
    output logic                   up_grant,
    output logic                   down_ready,
    output logic                   up_ready,
    output logic [CNT_W-1:0]       cycle_count
);

    logic [CNT_W-1:0] count_reg;
    logic [11:0]      down_limit;
    logic [11:0]      up_limit;

    // ****************************************************************
    // interval limits for both directions
    // ****************************************************************
    assign down_limit = fai_interval_cycles(interval_code, 1'b0);
    assign up_limit   = fai_interval_cycles(interval_code, 1'b1);

    // compare against the live code so a new code takes effect at once
    assign down_ready = (count_reg >= down_limit);
    assign up_ready   = (count_reg >= up_limit);

    // a step is only granted once its interval has elapsed
    assign down_grant = enable & down_req & down_ready;
    assign up_grant   = enable & up_req & up_ready & ~down_grant;

    assign cycle_count = count_reg;

    // ****************************************************************
    // monitoring-cycle counter
    // ****************************************************************
    // restart beats a coinciding tick; saturate so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (down_grant || up_grant) begin
            count_reg <= '0;
        end else if (monitor_tick && (count_reg < CNT_MAX)) begin
            count_reg <= count_reg + 12'h001;
        end
    end

endmodule : fai_interval

// >>> src/fai_pkg.sv
// Purpose: constants, register map and interval arithmetic shared by the
//          fan-start temperature interval block
// Assumes: 40 MHz clk, classic Wishbone slave with 32-bit data
// Notes:   registers sit at byte address = 4 * register index
//
// How it works
// - the local interval code is held in bits 5 to 3 of the codes register.
// - code n spaces decreases by 8*2^n and increases by 16*2^n cycles.
// - the remote 1 code doubles alike, 011 giving 64 and 128 cycles.
// - bits 7 to 6 hold the remote 2 low bits; its msb sits in register 0x36.
// - the joined remote 2 code spaces its steps, 000 giving 8 and 16 cycles.
// - the remote 1 code is held in bits 2 to 0 with the same encoding.
// - once lock is set the interval registers ignore every later write.

package fai_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_CTRL1      = 8'h36;
    localparam logic [7:0] IDX_CODES      = 8'h37;
    localparam logic [7:0] IDX_CONFIG     = 8'h40;
    localparam logic [7:0] IDX_STATUS     = 8'h41;
    localparam logic [7:0] IDX_CNT_LOCAL  = 8'h42;
    localparam logic [7:0] IDX_CNT_R1     = 8'h43;
    localparam logic [7:0] IDX_CNT_R2     = 8'h44;

    // ****************************************************************
    // reset values and field layout
    // ****************************************************************
    localparam logic [7:0] CTRL1_RST      = 8'h00;
    localparam logic [7:0] CODES_RST      = 8'h00;
    localparam logic [7:0] CTRL1_MASK     = 8'he1; // enables plus msb
    localparam int         CTRL1_R2MSB    = 0;
    localparam int         CTRL1_EN_R1    = 5;
    localparam int         CTRL1_EN_LOCAL = 6;
    localparam int         CTRL1_EN_R2    = 7;
    localparam int         CODES_R1_LSB   = 0;
    localparam int         CODES_LOC_LSB  = 3;
    localparam int         CODES_R2_LSB   = 6;
    localparam int         CFG_START      = 0;
    localparam int         CFG_LOCK       = 1;
    localparam int         CFG_READY      = 2;
    localparam logic       CFG_START_RST  = 1'h1;
    localparam int         STS_UP_LSB     = 3;

    // ****************************************************************
    // channels and interval arithmetic
    // ****************************************************************
    localparam int         NUM_CH         = 3;
    localparam int         CH_LOCAL       = 0;
    localparam int         CH_R1          = 1;
    localparam int         CH_R2          = 2;
    localparam int         CNT_W          = 12;
    localparam logic [11:0] DEC_BASE      = 12'h008;
    localparam logic [11:0] INC_BASE      = 12'h010;
    localparam logic [11:0] CNT_MAX       = 12'h800; // longest interval

    // monitoring cycles required before an adjustment in one direction
    function automatic logic [11:0] fai_interval_cycles(
        input logic [2:0] code,
        input logic       is_inc
    );
        logic [11:0] base;
        base = is_inc ? INC_BASE : DEC_BASE;
        return base << code;
    endfunction : fai_interval_cycles

    // word index of a Wishbone byte address
    function automatic logic [7:0] fai_word_index(input logic [9:0] adr);
        return adr[9:2];
    endfunction : fai_word_index

endpackage : fai_pkg

// >>> src/fai_top.sv
// Purpose: interval code registers and per-channel step spacing for the
//          dynamic fan-start temperature loop
// Assumes: classic Wishbone, inputs synchronous to clk, one clock
// Notes:   channel order in vectors is local, remote 1, remote 2
`timescale 1ns/1ps

module fai_top
    import fai_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [9:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // adjustment loop side
    input  wire logic              monitor_tick,
    input  wire logic [NUM_CH-1:0] adjust_down_req,
    input  wire logic [NUM_CH-1:0] adjust_up_req,
    output logic      [NUM_CH-1:0] adjust_down_grant,
    output logic      [NUM_CH-1:0] adjust_up_grant
);

    // ****************************************************************
    // reset synchroniser
    // ****************************************************************
    logic rst_meta_reg;
    logic rst_n_reg;

    // assert at once, release only after two clean edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [7:0]        ctrl1_reg;
    logic [7:0]        codes_reg;
    logic              start_reg;
    logic              lock_reg;
    logic              ready_reg;
    logic              ack_reg;
    logic [31:0]       dat_reg;
    logic [31:0]       rd_next;
    logic [7:0]        word_idx;
    logic              bus_req;
    logic              wr_commit;
    logic              lane0;
    logic [2:0]        local_interval_code;
    logic [2:0]        remote_one_interval_code;
    logic [2:0]        remote_two_interval_code;
    logic [2:0]        ch_code    [NUM_CH];
    logic [NUM_CH-1:0] ch_enable;
    logic [NUM_CH-1:0] down_ready;
    logic [NUM_CH-1:0] up_ready;
    logic [CNT_W-1:0]  ch_count   [NUM_CH];
    logic              tick_gated;

    // ****************************************************************
    // wishbone handshake
    // ****************************************************************
    assign word_idx  = fai_word_index(wb_adr_i);
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign lane0     = wb_sel_i[0];
    // a write lands on the same edge at which the master sees ack
    assign wr_commit = bus_req & wb_we_i & ack_reg & lane0;

    // one-cycle ack; it drops by itself so back-to-back cycles each get
    // a fresh answer after at least one idle edge
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ****************************************************************
    // interval code register
    // ****************************************************************
    // no write reaches it after lock, until the next reset
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            codes_reg <= CODES_RST;
        end else if (wr_commit && (word_idx == IDX_CODES) && !lock_reg) begin
            codes_reg <= wb_dat_i[7:0];
        end
    end

    // ****************************************************************
    // control register 1: channel enables and remote 2 code msb
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl1_reg <= CTRL1_RST;
        end else if (wr_commit && (word_idx == IDX_CTRL1) && !lock_reg) begin
            ctrl1_reg <= wb_dat_i[7:0] & CTRL1_MASK;
        end
    end

    // ****************************************************************
    // configuration: start stays writable, lock is write-once
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            start_reg <= CFG_START_RST;
        end else if (wr_commit && (word_idx == IDX_CONFIG)) begin
            start_reg <= wb_dat_i[CFG_START];
        end
    end

    // only a reset can clear lock; writing zero does nothing
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lock_reg <= 1'b0;
        end else if (wr_commit && (word_idx == IDX_CONFIG)
                     && wb_dat_i[CFG_LOCK]) begin
            lock_reg <= 1'b1;
        end
    end

    // ready rises on the first edge after reset release
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // code decode per channel
    // ****************************************************************
    assign local_interval_code      =
        codes_reg[CODES_LOC_LSB +: 3];
    assign remote_one_interval_code =
        codes_reg[CODES_R1_LSB +: 3];
    // top bit lives in the other register; both halves join here
    assign remote_two_interval_code =
        {ctrl1_reg[CTRL1_R2MSB], codes_reg[CODES_R2_LSB +: 2]};

    assign ch_code[CH_LOCAL] = local_interval_code;
    assign ch_code[CH_R1]    = remote_one_interval_code;
    assign ch_code[CH_R2]    = remote_two_interval_code;

    assign ch_enable[CH_LOCAL] = ctrl1_reg[CTRL1_EN_LOCAL];
    assign ch_enable[CH_R1]    = ctrl1_reg[CTRL1_EN_R1];
    assign ch_enable[CH_R2]    = ctrl1_reg[CTRL1_EN_R2];

    // with monitoring stopped no cycles elapse, so spacing freezes
    assign tick_gated = monitor_tick & start_reg;

    // ****************************************************************
    // per-channel spacing counters
    // ****************************************************************
    // each channel runs its own counter so one busy zone never
    // delays the others
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        fai_interval u_interval (
            .clk           (clk),
            .rst_n         (rst_n_reg),
            .monitor_tick  (tick_gated),
            .enable        (ch_enable[ch]),
            .interval_code (ch_code[ch]),
            .down_req      (adjust_down_req[ch]),
            .up_req        (adjust_up_req[ch]),
            .down_grant    (adjust_down_grant[ch]),
            .up_grant      (adjust_up_grant[ch]),
            .down_ready    (down_ready[ch]),
            .up_ready      (up_ready[ch]),
            .cycle_count   (ch_count[ch])
        );
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // unmapped words read as zero and are still acknowledged
    always_comb begin
        rd_next = 32'h0000_0000;
        case (word_idx)
            IDX_CTRL1: begin
                rd_next = {24'h00_0000, ctrl1_reg};
            end
            IDX_CODES: begin
                rd_next = {24'h00_0000, codes_reg};
            end
            IDX_CONFIG: begin
                rd_next[CFG_START] = start_reg;
                rd_next[CFG_LOCK]  = lock_reg;
                rd_next[CFG_READY] = ready_reg;
            end
            IDX_STATUS: begin
                rd_next[NUM_CH-1:0]                  = down_ready;
                rd_next[STS_UP_LSB +: NUM_CH]        = up_ready;
            end
            IDX_CNT_LOCAL: begin
                rd_next = {20'h0_0000, ch_count[CH_LOCAL]};
            end
            IDX_CNT_R1: begin
                rd_next = {20'h0_0000, ch_count[CH_R1]};
            end
            IDX_CNT_R2: begin
                rd_next = {20'h0_0000, ch_count[CH_R2]};
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // sampled on the request edge so it is stable across the ack cycle
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dat_reg <= 32'h0000_0000;
        end else if (bus_req && !ack_reg) begin
            dat_reg <= rd_next;
        end
    end

endmodule : fai_top
